// ### logic/prio_regs_pkg.sv
// Purpose: Constants shared by the source priority register block.
// Assumes: AHB-Lite slave with 32-bit data, one aligned word per register.
// Notes: Register fields are 3 bits wide, one unused bit above each field.
`default_nettype none
package prio_regs_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	// Byte offsets of the three priority registers.
	localparam logic [11:0] OFF_SRC_PRIO_0 = 12'h000;
	localparam logic [11:0] OFF_SRC_PRIO_1 = 12'h004;
	localparam logic [11:0] OFF_SRC_PRIO_2 = 12'h008;
	// Field positions (low bit of each 3-bit field).
	localparam int FLD_HI = 12;
	localparam int FLD_MH = 8;
	localparam int FLD_ML = 4;
	localparam int FLD_LO = 0;
	// Priority field width and reset value (level 4).
	localparam int LVL_W = 3;
	localparam logic [2:0] LVL_RESET = 3'h4;
	// Level that marks a source as disabled.
	localparam logic [2:0] LVL_OFF = 3'h0;
	// Number of sources served by this block.
	localparam int NUM_SRC = 11;
	// Writable bit masks of the three registers.
	localparam logic [15:0] MASK_0 = 16'h7777;
	localparam logic [15:0] MASK_1 = 16'h7770;
	localparam logic [15:0] MASK_2 = 16'h7777;
	// Reset values of the three registers.
	localparam logic [15:0] RST_0 = 16'h4444;
	localparam logic [15:0] RST_1 = 16'h4440;
	localparam logic [15:0] RST_2 = 16'h4444;
	// AHB transfer type codes.
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage
`default_nettype wire

// ### logic/prio_arbiter.sv
// Purpose: Picks the highest nonzero level among pending, enabled sources.
// Assumes: Inputs come from logic on the same clock.
// Notes: Ties go to the lowest source index; result is registered.
`default_nettype none
module prio_arbiter #(
	parameter int N = 11
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [N*3-1:0] levels,
	input wire logic [N-1:0] pending,
	output logic winner_valid,
	output logic [4:0] winner_id,
	output logic [2:0] winner_level
);
	import prio_regs_pkg::*;

	// Refuse a source count that the 5-bit index cannot name.
	if (N < 1 || N > 31) begin : g_chk
		$error("prio_arbiter: N out of range");
	end

	// Combinational search result.
	logic [2:0] best_lvl;
	logic [4:0] best_id;

	// Scan sources; a level of zero never wins, so disabled sources drop out.
	always_comb begin
		best_lvl = LVL_OFF;
		best_id = 5'h00;
		for (int i = 0; i < N; i++) begin
			if (pending[i] && levels[i*3 +: 3] > best_lvl) begin
				best_lvl = levels[i*3 +: 3];
				best_id = 5'(i);
			end
		end
	end

	// Register the winner so the outputs leave from flip-flops.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			winner_valid <= 1'b0;
			winner_id <= 5'h00;
			winner_level <= 3'h0;
		end else begin
			winner_valid <= (best_lvl != LVL_OFF);
			winner_id <= best_id;
			winner_level <= best_lvl;
		end
	end
endmodule
`default_nettype wire

// ### logic/source_priority_regs.sv
// Purpose: Three source priority registers on AHB-Lite, with level outputs.
// Assumes: Single 32-bit transfers; registers hold 16 bits in the low half.
// Notes: Zero wait states; every response is OKAY.
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`default_nettype none

// ----------------------------------------------------------------
// Source priority register block
// ----------------------------------------------------------------
// Summary of operation
// - Field 111 is level 7, 001 level 1.
// - Every field resets to 100, read/write.
// - Unimplemented bits ignore writes, read zero.
// - Register 0 holds timer1, compare1, capture1, ext0.
// - Register 1 holds timer2, compare2, capture2.
// - Register 2 holds serial rx, sync serial event.
// - Register 2 holds sync serial fault, timer3.
module source_priority_regs (
	input wire logic CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic [prio_regs_pkg::NUM_SRC-1:0] IRQ_PENDING,
	output logic [2:0] TIMER_ONE_LEVEL,
	output logic [2:0] OUT_COMPARE_ONE_LEVEL,
	output logic [2:0] IN_CAPTURE_ONE_LEVEL,
	output logic [2:0] EXT_IRQ_ZERO_LEVEL,
	output logic [2:0] TIMER_TWO_LEVEL,
	output logic [2:0] OUT_COMPARE_TWO_LEVEL,
	output logic [2:0] IN_CAPTURE_TWO_LEVEL,
	output logic [2:0] SERIAL_ONE_RX_LEVEL,
	output logic [2:0] SYNC_SERIAL_ONE_EVENT_LEVEL,
	output logic [2:0] SYNC_SERIAL_ONE_FAULT_LEVEL,
	output logic [2:0] TIMER_THREE_LEVEL,
	output logic SERVICE_VALID,
	output logic [4:0] SERVICE_ID,
	output logic [2:0] SERVICE_LEVEL
);
	import prio_regs_pkg::*;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// Register contents, indexed by register number.
	logic [15:0] prio_r [3];
	// Writable masks and reset values per register index.
	localparam logic [15:0] MASKS [3] = '{MASK_0, MASK_1, MASK_2};
	localparam logic [15:0] RSTS [3] = '{RST_0, RST_1, RST_2};

	// Latched address phase of a pending write.
	logic wr_pend_r;
	logic [1:0] wr_idx_r;
	logic wr_hit_r;

	// Decode of the current address phase.
	logic addr_take;
	logic [1:0] addr_idx;
	logic addr_hit;

	// Maps a byte address to a register index; index 3 is unmapped.
	function automatic logic [1:0] reg_index(input logic [31:0] a);
		logic [1:0] r;
		r = 2'h3;
		if (a[31:12] == 20'h00000) begin
			case (a[11:0])
				OFF_SRC_PRIO_0: r = 2'h0;
				OFF_SRC_PRIO_1: r = 2'h1;
				OFF_SRC_PRIO_2: r = 2'h2;
				default: r = 2'h3;
			endcase
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Address phase
	// ----------------------------------------------------------------
	// A transfer is taken when selected, active and the bus is ready.
	always_comb begin
		addr_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == 2'h3);
		addr_idx = reg_index(HADDR);
		addr_hit = (addr_idx != 2'h3);
	end

	// Remember a write address phase for the following data phase.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wr_pend_r <= 1'b0;
			wr_idx_r <= 2'h0;
			wr_hit_r <= 1'b0;
		end else begin
			wr_pend_r <= addr_take && HWRITE;
			wr_idx_r <= addr_idx;
			wr_hit_r <= addr_hit;
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// Only implemented bits take data; the rest stay zero.
	generate
		for (genvar g = 0; g < 3; g++) begin : g_reg
			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					prio_r[g] <= RSTS[g];
				end else if (wr_pend_r && wr_hit_r && wr_idx_r == 2'(g)) begin
					prio_r[g] <= HWDATA[15:0] & MASKS[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read data and response
	// ----------------------------------------------------------------
	// Read data is captured at the address phase; unmapped reads give zero.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			HRDATA <= 32'h00000000;
		end else if (addr_take && !HWRITE) begin
			if (addr_hit) begin
				HRDATA <= {16'h0000, prio_r[addr_idx] & MASKS[addr_idx]};
			end else begin
				HRDATA <= 32'h00000000;
			end
		end
	end

	// The slave never stalls and always answers OKAY.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Level outputs
	// ----------------------------------------------------------------
	// Fields are passed as-is: 111 is level 7 down to 001 as level 1.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			TIMER_ONE_LEVEL <= LVL_RESET;
			OUT_COMPARE_ONE_LEVEL <= LVL_RESET;
			IN_CAPTURE_ONE_LEVEL <= LVL_RESET;
			EXT_IRQ_ZERO_LEVEL <= LVL_RESET;
			TIMER_TWO_LEVEL <= LVL_RESET;
			OUT_COMPARE_TWO_LEVEL <= LVL_RESET;
			IN_CAPTURE_TWO_LEVEL <= LVL_RESET;
			SERIAL_ONE_RX_LEVEL <= LVL_RESET;
			SYNC_SERIAL_ONE_EVENT_LEVEL <= LVL_RESET;
			SYNC_SERIAL_ONE_FAULT_LEVEL <= LVL_RESET;
			TIMER_THREE_LEVEL <= LVL_RESET;
		end else begin
			TIMER_ONE_LEVEL <= prio_r[0][FLD_HI +: LVL_W];
			OUT_COMPARE_ONE_LEVEL <= prio_r[0][FLD_MH +: LVL_W];
			IN_CAPTURE_ONE_LEVEL <= prio_r[0][FLD_ML +: LVL_W];
			EXT_IRQ_ZERO_LEVEL <= prio_r[0][FLD_LO +: LVL_W];
			TIMER_TWO_LEVEL <= prio_r[1][FLD_HI +: LVL_W];
			OUT_COMPARE_TWO_LEVEL <= prio_r[1][FLD_MH +: LVL_W];
			IN_CAPTURE_TWO_LEVEL <= prio_r[1][FLD_ML +: LVL_W];
			SERIAL_ONE_RX_LEVEL <= prio_r[2][FLD_HI +: LVL_W];
			SYNC_SERIAL_ONE_EVENT_LEVEL <= prio_r[2][FLD_MH +: LVL_W];
			SYNC_SERIAL_ONE_FAULT_LEVEL <= prio_r[2][FLD_ML +: LVL_W];
			TIMER_THREE_LEVEL <= prio_r[2][FLD_LO +: LVL_W];
		end
	end

	// ----------------------------------------------------------------
	// Arbitration
	// ----------------------------------------------------------------
	// Source order: index 0..10 as the level outputs above.
	logic [NUM_SRC*3-1:0] all_levels;
	assign all_levels = {prio_r[2][FLD_LO +: 3], prio_r[2][FLD_ML +: 3],
		prio_r[2][FLD_MH +: 3], prio_r[2][FLD_HI +: 3], prio_r[1][FLD_ML +: 3],
		prio_r[1][FLD_MH +: 3], prio_r[1][FLD_HI +: 3], prio_r[0][FLD_LO +: 3],
		prio_r[0][FLD_ML +: 3], prio_r[0][FLD_MH +: 3], prio_r[0][FLD_HI +: 3]};

	// The arbiter registers its result, so service outputs are flip-flops.
	prio_arbiter #(.N(NUM_SRC)) u_arb (
		.clk(CLK),
		.rst(RST),
		.levels(all_levels),
		.pending(IRQ_PENDING),
		.winner_valid(SERVICE_VALID),
		.winner_id(SERVICE_ID),
		.winner_level(SERVICE_LEVEL)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// A write data phase to register 0.
	sequence s_write0;
		wr_pend_r && wr_hit_r && wr_idx_r == 2'h0;
	endsequence
	// A write data phase to register 1.
	sequence s_write1;
		wr_pend_r && wr_hit_r && wr_idx_r == 2'h1;
	endsequence
	// A write data phase to register 2.
	sequence s_write2;
		wr_pend_r && wr_hit_r && wr_idx_r == 2'h2;
	endsequence
	// A write data phase to an address that maps to no register.
	sequence s_write_miss;
		wr_pend_r && !wr_hit_r;
	endsequence
	// A read address phase of register 1, whose low nibble is unused.
	sequence s_read1;
		addr_take && !HWRITE && addr_idx == 2'h1;
	endsequence

	AST_UNUSED_ZERO: assert property (@(posedge CLK) disable iff (RST)
		(prio_r[0] & ~MASK_0) == 16'h0 && (prio_r[1] & ~MASK_1) == 16'h0 &&
		(prio_r[2] & ~MASK_2) == 16'h0)
		else $error("Unimplemented bit became set.");
	AST_RD_UPPER: assert property (@(posedge CLK) disable iff (RST)
		HRDATA[31:15] == 17'h0 && HRDATA[11] == 1'b0 && HRDATA[7] == 1'b0)
		else $error("Reserved read bits not zero.");
	AST_RESET_VAL: assert property (@(posedge CLK) $fell(RST) |->
		prio_r[0] == RST_0 && prio_r[1] == RST_1 && prio_r[2] == RST_2)
		else $error("Registers did not reset to level 4.");
	AST_WR_UPDATE: assert property (@(posedge CLK) disable iff (RST)
		s_write0 |=> prio_r[0] == ($past(HWDATA[15:0]) & MASK_0))
		else $error("Write to register 0 not stored.");
	AST_T1_LEVEL: assert property (@(posedge CLK) disable iff (RST)
		##1 TIMER_ONE_LEVEL == $past(prio_r[0][14:12]))
		else $error("Timer1 level mismatch.");
	AST_IC2_LEVEL: assert property (@(posedge CLK) disable iff (RST)
		##1 IN_CAPTURE_TWO_LEVEL == $past(prio_r[1][6:4]))
		else $error("Capture2 level mismatch.");
	AST_RX_LEVEL: assert property (@(posedge CLK) disable iff (RST)
		##1 SERIAL_ONE_RX_LEVEL == $past(prio_r[2][14:12]))
		else $error("Serial rx level mismatch.");
	AST_T3_LEVEL: assert property (@(posedge CLK) disable iff (RST)
		##1 TIMER_THREE_LEVEL == $past(prio_r[2][2:0]))
		else $error("Timer3 level mismatch.");
	AST_NO_ZERO_WIN: assert property (@(posedge CLK) disable iff (RST)
		SERVICE_VALID |-> SERVICE_LEVEL != LVL_OFF)
		else $error("Disabled source serviced.");
	AST_IDLE_NONE: assert property (@(posedge CLK) disable iff (RST)
		IRQ_PENDING == '0 |=> !SERVICE_VALID)
		else $error("Service without pending source.");
	AST_LVL7_WINS: assert property (@(posedge CLK) disable iff (RST)
		(IRQ_PENDING[0] && prio_r[0][14:12] == 3'h7) |=> SERVICE_LEVEL == 3'h7)
		else $error("Level 7 did not win.");

	// Every other level output follows its field one cycle later.
	AST_OC1_LEVEL: assert property (@(posedge CLK) disable iff (RST)
		##1 OUT_COMPARE_ONE_LEVEL == $past(prio_r[0][10:8]))
		else $error("Compare1 level mismatch.");
	AST_IC1_LEVEL: assert property (@(posedge CLK) disable iff (RST)
		##1 IN_CAPTURE_ONE_LEVEL == $past(prio_r[0][6:4]))
		else $error("Capture1 level mismatch.");
	AST_EXT0_LEVEL: assert property (@(posedge CLK) disable iff (RST)
		##1 EXT_IRQ_ZERO_LEVEL == $past(prio_r[0][2:0]))
		else $error("External0 level mismatch.");
	AST_T2_LEVEL: assert property (@(posedge CLK) disable iff (RST)
		##1 TIMER_TWO_LEVEL == $past(prio_r[1][14:12]))
		else $error("Timer2 level mismatch.");
	AST_OC2_LEVEL: assert property (@(posedge CLK) disable iff (RST)
		##1 OUT_COMPARE_TWO_LEVEL == $past(prio_r[1][10:8]))
		else $error("Compare2 level mismatch.");
	AST_SYNC_EV_LEVEL: assert property (@(posedge CLK) disable iff (RST)
		##1 SYNC_SERIAL_ONE_EVENT_LEVEL == $past(prio_r[2][10:8]))
		else $error("Sync serial event level mismatch.");
	AST_SYNC_FLT_LEVEL: assert property (@(posedge CLK) disable iff (RST)
		##1 SYNC_SERIAL_ONE_FAULT_LEVEL == $past(prio_r[2][6:4]))
		else $error("Sync serial fault level mismatch.");

	// Writes to the other two registers keep only their implemented bits.
	AST_WR1_UPDATE: assert property (@(posedge CLK) disable iff (RST)
		s_write1 |=> prio_r[1] == ($past(HWDATA[15:0]) & MASK_1))
		else $error("Write to register 1 not stored.");
	AST_WR2_UPDATE: assert property (@(posedge CLK) disable iff (RST)
		s_write2 |=> prio_r[2] == ($past(HWDATA[15:0]) & MASK_2))
		else $error("Write to register 2 not stored.");
	// A write that hits no register must leave all of them alone.
	AST_WR_MISS: assert property (@(posedge CLK) disable iff (RST)
		s_write_miss |=> $stable(prio_r[0]) && $stable(prio_r[1]) && $stable(prio_r[2]))
		else $error("Unmapped write changed a register.");
	// Unused read bits stay zero, including the empty low nibble of register 1.
	AST_RD1_LOW: assert property (@(posedge CLK) disable iff (RST)
		s_read1 |=> HRDATA[3:0] == 4'h0)
		else $error("Register 1 low nibble read not zero.");
	AST_RD_BIT3: assert property (@(posedge CLK) disable iff (RST)
		HRDATA[3] == 1'b0)
		else $error("Read bit 3 not zero.");
	// Refused accesses are still answered at once and without error.
	AST_READY_OKAY: assert property (@(posedge CLK) disable iff (RST)
		HREADYOUT && !HRESP)
		else $error("Slave stalled or answered with an error.");
	// A pending timer1 source whose field is zero is never the winner.
	AST_ZERO_NEVER: assert property (@(posedge CLK) disable iff (RST)
		(IRQ_PENDING[0] && prio_r[0][14:12] == 3'h0) |=>
		!(SERVICE_VALID && SERVICE_ID == 5'h00))
		else $error("Disabled timer1 source serviced.");
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the source priority register block.
// Assumes: Zero-wait AHB-Lite slave; level and service outputs are registered.
// Notes: A queue-free integer model mirrors the registers and the arbitration.
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import prio_regs_pkg::*;
	// ----------------------------------------------------------------
	// Signals and model state
	// ----------------------------------------------------------------
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0] htrans = HTRANS_IDLE;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [NUM_SRC-1:0] pend = '0;
	wire logic [31:0] hrdata;
	wire logic hreadyout, hresp, sv_valid;
	wire logic [4:0] sv_id;
	wire logic [2:0] sv_level;
	wire logic [32:0] lv;
	int n_errors = 0, n_compared = 0, seed = 57591;
	logic [15:0] m[3] = '{RST_0, RST_1, RST_2}; // Model copy of the registers.
	logic [15:0] msk[3] = '{MASK_0, MASK_1, MASK_2}; // Writable bits.
	int rg[11] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2}; // Register of each source.
	int sh[11] = '{12, 8, 4, 0, 12, 8, 4, 12, 8, 4, 0}; // Field position.
	// Half-period toggle gives the 5 ns clock.
	always #2.5 CLK = ~CLK;
	source_priority_regs uut (.CLK(CLK), .RST(RST), .HSEL(1'b1), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.IRQ_PENDING(pend), .TIMER_ONE_LEVEL(lv[32:30]), .OUT_COMPARE_ONE_LEVEL(lv[29:27]),
		.IN_CAPTURE_ONE_LEVEL(lv[26:24]), .EXT_IRQ_ZERO_LEVEL(lv[23:21]),
		.TIMER_TWO_LEVEL(lv[20:18]), .OUT_COMPARE_TWO_LEVEL(lv[17:15]),
		.IN_CAPTURE_TWO_LEVEL(lv[14:12]), .SERIAL_ONE_RX_LEVEL(lv[11:9]),
		.SYNC_SERIAL_ONE_EVENT_LEVEL(lv[8:6]), .SYNC_SERIAL_ONE_FAULT_LEVEL(lv[5:3]),
		.TIMER_THREE_LEVEL(lv[2:0]), .SERVICE_VALID(sv_valid), .SERVICE_ID(sv_id),
		.SERVICE_LEVEL(sv_level));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Model field of one source, which is also its level.
	function automatic logic [2:0] fld(input int i);
		fld = m[rg[i]][sh[i] +: 3];
	endfunction
	// One single AHB transfer; the model follows writes, reads are compared.
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		logic [31:0] exp;
		exp = 32'h0;
		@(posedge CLK);
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		// Only the watchdog ends a wait for the slave.
		do @(posedge CLK); while (hreadyout !== 1'b1);
		htrans <= HTRANS_IDLE;
		hwdata <= wd;
		do @(posedge CLK); while (hreadyout !== 1'b1);
		for (int r = 0; r < 3; r++) begin
			if (a == 32'(r * 4)) begin
				if (wr) m[r] = wd[15:0] & msk[r];
				exp = {16'h0, m[r]};
			end
		end
		if (!wr) `CHK(hrdata, exp)
		`CHK(hresp, 1'b0)
	endtask
	// Level outputs must equal the model fields in source order.
	task automatic chk_levels();
		logic [32:0] e;
		for (int i = 0; i < NUM_SRC; i++) e[(10 - i) * 3 +: 3] = fld(i);
		repeat (2) @(posedge CLK);
		@(negedge CLK);
		`CHK(lv, e)
	endtask
	// Random pending sets; winner is the highest nonzero level, lowest index.
	task automatic chk_arb();
		int best;
		for (int n = 0; n < 4; n++) begin
			@(posedge CLK);
			pend <= NUM_SRC'($random(seed));
			@(posedge CLK);
			best = -1;
			for (int i = 0; i < NUM_SRC; i++) begin
				if (pend[i] && fld(i) != 3'h0 && (best < 0 || fld(i) > fld(best))) best = i;
			end
			@(negedge CLK);
			`CHK(sv_valid, best >= 0)
			`CHK(sv_level, (best >= 0) ? fld(best) : 3'h0)
			if (best >= 0) `CHK(sv_id, 5'(best))
		end
	endtask
	// Prints the verdict and ends the run.
	task automatic stop_test();
		if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int r;
		logic [31:0] d;
		repeat (9) @(posedge CLK);
		// Outputs while reset is still held.
		chk_levels();
		`CHK(hreadyout, 1'b1)
		`CHK(hrdata, 32'h0)
		`CHK(sv_valid, 1'b0)
		@(posedge CLK);
		RST <= 1'b0;
		// Reset values of all three registers and of every level.
		for (r = 0; r < 3; r++) ahb(1'b0, 32'(r * 4), 32'h0);
		chk_levels();
		// All ones, then all zeros, then random words into each register.
		for (int it = 0; it < 18; it++) begin
			r = it % 3;
			d = (it < 3) ? 32'hffffffff : (it < 6) ? 32'h0 : $random(seed);
			ahb(1'b1, 32'(r * 4), d);
			ahb(1'b0, 32'(r * 4), 32'h0);
			chk_levels();
			chk_arb();
		end
		// Unmapped place: write ignored, reads zero, registers untouched.
		ahb(1'b1, 32'h1000, 32'hffffffff);
		ahb(1'b0, 32'h1000, 32'h0);
		for (r = 0; r < 3; r++) ahb(1'b0, 32'(r * 4), 32'h0);
		// Reset in mid-run brings every field back to level 4.
		RST <= 1'b1;
		m = '{RST_0, RST_1, RST_2};
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		for (r = 0; r < 3; r++) ahb(1'b0, 32'(r * 4), 32'h0);
		chk_levels();
		chk_arb();
		stop_test();
	end
	// Watchdog cuts a hang short well beyond the expected run length.
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end
endmodule
`default_nettype wire
